// ### hdl/spi_flash_pkg.sv
// constants, types and encodings shared by the spi flash command slave
package spi_flash_pkg;

    // =========================================================
    // command opcodes
    localparam logic [7:0] latch_set_cmd        = 8'h06;
    localparam logic [7:0] latch_clear_cmd      = 8'h04;
    localparam logic [7:0] status_read_cmd      = 8'h05;
    localparam logic [7:0] status_write_cmd     = 8'h01;
    localparam logic [7:0] data_read_cmd        = 8'h03;
    localparam logic [7:0] data_write_cmd       = 8'h02;
    localparam logic [7:0] part_erase_cmd       = 8'h20;
    localparam logic [7:0] full_array_erase_cmd = 8'h60;

    // =========================================================
    // status register layout
    localparam int         ST_BUSY       = 0;
    localparam int         ST_LATCH      = 1;
    localparam int         ST_PROT_LO    = 2;
    localparam int         ST_PROT_HI    = 3;
    localparam int         STATUS_W      = 8;
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [3:0] STATUS_UNUSED = 4'h0;

    // =========================================================
    // bit counts, widths and limits; the LAST values give the index of the last bit
    localparam logic [4:0] OPC_LAST       = 5'h07;
    localparam logic [4:0] EXT_FIELD_LAST = 5'h0F;
    localparam logic [4:0] BASE_FIELD_LAST = 5'h07;
    localparam logic [4:0] STAT_LAST      = 5'h07;
    localparam logic [4:0] STAT_EXACT     = 5'h08;
    localparam logic [4:0] STAT_OVER      = 5'h09;
    localparam int         EXT_DATA_W     = 16;
    localparam int         BASE_DATA_W    = 8;
    localparam int         ADDR_W         = 9;
    localparam int         EXT_SECTOR_BIT = 8;
    localparam logic [7:0] BASE_LAST_ADDR = 8'hFF;

    // =========================================================
    // erase sector selects
    localparam logic [1:0] ERASE_SECTOR_ZERO = 2'h1;
    localparam logic [1:0] ERASE_SECTOR_ONE  = 2'h2;
    localparam logic [1:0] ERASE_BOTH        = 2'h3;

    // interface sequencer states
    typedef enum logic [2:0] {
        IF_OPCODE,
        IF_ADDR,
        IF_RD_DATA,
        IF_WR_DATA,
        IF_STAT_OUT,
        IF_STAT_IN,
        IF_IGNORE
    } if_state_e;

    // serial pins sampled together
    typedef struct packed {
        logic sck;
        logic cs_n;
        logic si;
    } spi_pins_s;

endpackage

// ### hdl/spi_flash_command_slave.sv
// spi slave command interpreter in front of the user flash array
//
// What this block does
// R01 - first byte after select must be valid opcode, else ignore until deselect
// R02 - chip select high returns to idle; each request starts at falling select
// R03 - decode 06 latch set, 04 latch clear, 05 status read
// R04 - decode 03 as data read
// R05 - decode 02 as data write
// R06 - decode 20 as one sector erase, 60 as whole array erase
// R07 - status bits 7..4 zero, 3..2 protection, 1 latch, 0 busy; reset zero
// R08 - latch bit reads 1 when writes enabled, 0 otherwise
// R09 - busy bit reads 1 during internal write or erase
// R10 - read-only build has no status register at all
// R11 - every field shifts most significant bit first
// R12 - extended address is 16 bits; first seven dropped, nine kept
// R13 - extended read streams incrementing words, wrapping to zero
// R14 - read stream continues until chip select rises
// R15 - read opcode ignored while programming is in progress
// R16 - base read takes byte address, increments, stops at 255
// R17 - base read floats output after last bit of address 255
// R18 - master writes only locations already erased to all ones
// R19 - write opcode ignored while programming is in progress
// R20 - write data skipped unless latch set and address unprotected
// R21 - extended write takes one 16-bit word, base one byte
// R22 - internal write or erase starts only after chip select rises
// R23 - extended sector erase: address bit after seven dropped picks sector
// R24 - sector erase needs latch set and sector unprotected
// R25 - base sector erase has no address, always erases sector zero
// R26 - decode 01 as status write
// R27 - sample input on rising serial clock, drive output on falling
// R28 - base mode 8-bit address and data, extended mode 16-bit
// R29 - write and erase leave latch alone; only latch clear resets it
// R30 - bits after write data are ignored until deselect
`timescale 1ns/1ps
`default_nettype none

module spi_flash_command_slave
    import spi_flash_pkg::*;
#(
    parameter bit EXTENDED  = 1'b1,
    parameter bit READ_ONLY = 1'b0
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          sck,
    input  wire logic          cs_n,
    input  wire logic          si,
    output logic               so_out,
    output logic               so_oe_n,
    output logic               rd_req,
    output logic [ADDR_W-1:0]  rd_addr,
    input  wire logic          rd_valid,
    input  wire logic [15:0]   rd_data,
    output logic               prog_start,
    output logic [ADDR_W-1:0]  prog_addr,
    output logic [15:0]        prog_data,
    output logic               erase_start,
    output logic [1:0]         erase_sel,
    input  wire logic          flash_busy,
    output logic [7:0]         flash_interface_status
);

    // =========================================================
    // mode dependent widths
    localparam int         DATA_W     = EXTENDED ? EXT_DATA_W : BASE_DATA_W;
    localparam logic [4:0] FIELD_LAST = EXTENDED ? EXT_FIELD_LAST
                                                 : BASE_FIELD_LAST;

    spi_pins_s   pin_s1_r;
    spi_pins_s   pin_s2_r;
    logic        sck_d_r;
    logic        cs_d_r;
    if_state_e   state_r;
    logic [4:0]  bit_cnt_r;
    logic [15:0] shift_in_r;
    logic [7:0]  opcode_r;
    logic [15:0] tx_r;
    logic [15:0] word_r;
    logic [4:0]  tx_idx_r;
    logic        last_r;
    logic        latch_r;
    logic [1:0]  prot_r;
    logic        busy_r;
    logic        pend_prog_r;
    logic        pend_erase_r;
    logic [1:0]  pend_sel_r;

    // =========================================================
    // pin synchroniser; only the second stage is looked at
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_s1_r <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0};
            pin_s2_r <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0};
            sck_d_r  <= 1'b0;
            cs_d_r   <= 1'b1;
        end else begin
            pin_s1_r <= '{sck: sck, cs_n: cs_n, si: si};
            pin_s2_r <= pin_s1_r;
            sck_d_r  <= pin_s2_r.sck;
            cs_d_r   <= pin_s2_r.cs_n;
        end
    end

    // edge events seen by the system clock
    wire selected = ~pin_s2_r.cs_n;
    wire sck_rise = selected & pin_s2_r.sck & ~sck_d_r;       // R27
    wire sck_fall = selected & ~pin_s2_r.sck & sck_d_r;       // R27
    wire cs_rise  = pin_s2_r.cs_n & ~cs_d_r;

    // incoming bits enter at the bottom so the first is the msb
    wire [15:0] shift_nxt = {shift_in_r[14:0], pin_s2_r.si};  // R11
    wire [7:0]  opc_byte  = shift_nxt[7:0];
    wire        opc_full  = sck_rise & (state_r == IF_OPCODE)
                            & (bit_cnt_r == OPC_LAST);

    // =========================================================
    // opcode qualification; during busy only status read survives
    wire rw_ok        = ~READ_ONLY & ~busy_r;
    wire op_read      = (opc_byte == data_read_cmd) & ~busy_r;    // R04 R15
    wire op_write     = (opc_byte == data_write_cmd) & rw_ok;     // R05 R19
    wire op_set       = (opc_byte == latch_set_cmd) & rw_ok;      // R03
    wire op_clear     = (opc_byte == latch_clear_cmd) & rw_ok;    // R03
    wire op_stat_rd   = (opc_byte == status_read_cmd) & ~READ_ONLY; // R03 R10
    wire op_stat_wr   = (opc_byte == status_write_cmd) & rw_ok;   // R26
    wire op_perase    = (opc_byte == part_erase_cmd) & rw_ok;     // R06
    wire op_ferase    = (opc_byte == full_array_erase_cmd) & rw_ok; // R06
    wire needs_addr   = op_read | op_write | (op_perase & EXTENDED);

    // latch set, latch clear and address-free erases fall into the wait
    wire if_state_e op_next = needs_addr ? IF_ADDR :              // R01
                              op_stat_rd ? IF_STAT_OUT :
                              op_stat_wr ? IF_STAT_IN : IF_IGNORE;

    // =========================================================
    // address phase
    wire addr_done = sck_rise & (state_r == IF_ADDR)
                     & (bit_cnt_r == FIELD_LAST);
    // extended keeps the low nine bits, dropping the first seven
    wire [ADDR_W-1:0] cap_addr = EXTENDED ? shift_nxt[ADDR_W-1:0]  // R12
                                          : {1'b0, shift_nxt[7:0]}; // R28
    wire sector_bit  = shift_nxt[EXT_SECTOR_BIT];                  // R23
    wire protected_w = &prot_r;
    wire wr_allowed  = latch_r & ~protected_w;                     // R20 R24
    wire is_read_op  = (opcode_r == data_read_cmd);
    wire is_write_op = (opcode_r == data_write_cmd);
    wire if_state_e addr_next = is_read_op ? IF_RD_DATA :
                                (is_write_op & wr_allowed) ? IF_WR_DATA :
                                IF_IGNORE;                         // R20
    wire data_last = (bit_cnt_r == FIELD_LAST);
    wire wr_done   = sck_rise & (state_r == IF_WR_DATA) & data_last; // R21

    // =========================================================
    // interface sequencer: deselect forces idle
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r    <= IF_OPCODE;
            bit_cnt_r  <= 5'h00;
            shift_in_r <= 16'h0000;
            opcode_r   <= 8'h00;
        end else if (!selected) begin
            state_r   <= IF_OPCODE;                                // R02
            bit_cnt_r <= 5'h00;
        end else if (sck_rise) begin
            shift_in_r <= shift_nxt;
            case (state_r)
                IF_OPCODE: begin
                    if (bit_cnt_r == OPC_LAST) begin
                        opcode_r  <= opc_byte;
                        bit_cnt_r <= 5'h00;
                        state_r   <= op_next;                      // R01
                    end else begin
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                    end
                end
                IF_ADDR: begin
                    if (bit_cnt_r == FIELD_LAST) begin
                        bit_cnt_r <= 5'h00;
                        state_r   <= addr_next;
                    end else begin
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                    end
                end
                IF_WR_DATA: begin
                    if (data_last) begin
                        state_r <= IF_IGNORE;                      // R30
                    end else begin
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                    end
                end
                IF_STAT_IN: begin
                    // saturate so a ninth bit is remembered as too long
                    if (bit_cnt_r != STAT_OVER) begin
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // =========================================================
    // status register; frozen while busy since no other op decodes
    always_ff @(posedge clk) begin
        if (reset) begin
            latch_r <= 1'b0;                                       // R07
            prot_r  <= 2'b00;
            busy_r  <= 1'b0;
        end else begin
            // busy covers the start pulse until the engine answers
            busy_r <= ~READ_ONLY & (flash_busy | prog_start
                                    | erase_start);                // R09
            if (opc_full & op_set) begin
                latch_r <= 1'b1;                                   // R08
            end else if (opc_full & op_clear) begin
                latch_r <= 1'b0;                                   // R29
            end
            // exactly eight bits, else the status write is dropped
            if (cs_rise & (state_r == IF_STAT_IN)
                & (bit_cnt_r == STAT_EXACT)) begin
                prot_r <= shift_in_r[ST_PROT_HI:ST_PROT_LO];
            end
        end
    end

    // read-only build keeps the register at zero
    wire [7:0] status_w = READ_ONLY ? STATUS_RESET :               // R10
                          {STATUS_UNUSED, prot_r, latch_r, busy_r}; // R07

    always_ff @(posedge clk) begin
        if (reset) begin
            flash_interface_status <= STATUS_RESET;
        end else begin
            flash_interface_status <= status_w;
        end
    end

    // =========================================================
    // deferred program and erase, launched at deselect
    always_ff @(posedge clk) begin
        if (reset) begin
            pend_prog_r  <= 1'b0;
            pend_erase_r <= 1'b0;
            pend_sel_r   <= 2'b00;
            prog_start   <= 1'b0;
            prog_addr    <= '0;
            prog_data    <= 16'h0000;
            erase_start  <= 1'b0;
            erase_sel    <= 2'b00;
        end else begin
            prog_start  <= 1'b0;
            erase_start <= 1'b0;
            if (addr_done & is_write_op) begin
                prog_addr <= cap_addr;
            end
            if (wr_done) begin
                pend_prog_r <= 1'b1;                               // R21
                prog_data   <= EXTENDED ? shift_nxt
                                        : {8'h00, shift_nxt[7:0]};
            end
            if (addr_done & (opcode_r == part_erase_cmd) & wr_allowed) begin
                pend_erase_r <= 1'b1;                              // R23 R24
                pend_sel_r   <= sector_bit ? ERASE_SECTOR_ONE
                                           : ERASE_SECTOR_ZERO;
            end
            if (opc_full & ((op_perase & ~EXTENDED) | op_ferase)
                & wr_allowed) begin
                pend_erase_r <= 1'b1;                              // R25
                pend_sel_r   <= (op_ferase & EXTENDED) ? ERASE_BOTH
                                                       : ERASE_SECTOR_ZERO;
            end
            if (cs_rise) begin
                prog_start   <= pend_prog_r;                       // R22
                erase_start  <= pend_erase_r;                      // R22
                erase_sel    <= pend_sel_r;
                pend_prog_r  <= 1'b0;
                pend_erase_r <= 1'b0;
            end
        end
    end

    // =========================================================
    // serial output: data words, or bytes in base mode, for reads, repeating status byte
    wire rd_edge  = sck_fall & (state_r == IF_RD_DATA);
    wire st_edge  = sck_fall & (state_r == IF_STAT_OUT);
    wire end_addr = ~EXTENDED & (rd_addr[7:0] == BASE_LAST_ADDR);

    // fetched word waits here; the shifter keeps its own copy
    always_ff @(posedge clk) begin
        if (reset) begin
            word_r <= 16'h0000;
        end else if (rd_valid) begin
            word_r <= rd_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            so_out   <= 1'b0;
            so_oe_n  <= 1'b1;
            tx_r     <= 16'h0000;
            tx_idx_r <= 5'h00;
            last_r   <= 1'b0;
            rd_req   <= 1'b0;
            rd_addr  <= '0;
        end else begin
            rd_req <= 1'b0;
            if (!selected) begin
                so_oe_n  <= 1'b1;                                  // R14
                tx_idx_r <= 5'h00;
                last_r   <= 1'b0;
            end else begin
                if (addr_done & is_read_op) begin
                    rd_addr <= cap_addr;
                    rd_req  <= 1'b1;
                end
                if (rd_edge) begin
                    if (tx_idx_r != 5'h00) begin
                        so_out <= tx_r[DATA_W-1];                  // R11
                        tx_r   <= {tx_r[14:0], 1'b0};
                    end else if (last_r) begin
                        so_oe_n <= 1'b1;                           // R17
                    end else begin
                        so_out  <= word_r[DATA_W-1];
                        tx_r    <= {word_r[14:0], 1'b0};
                        so_oe_n <= 1'b0;
                        // prefetch the next word while this one shifts
                        if (end_addr) begin
                            last_r <= 1'b1;                        // R16
                        end else begin
                            rd_addr <= rd_addr + 9'h001;           // R13
                            rd_req  <= 1'b1;
                        end
                    end
                    tx_idx_r <= (tx_idx_r == FIELD_LAST) ? 5'h00
                                                         : tx_idx_r + 5'h01;
                end
                if (st_edge) begin
                    if (tx_idx_r == 5'h00) begin
                        so_out <= flash_interface_status[STATUS_W-1];
                        tx_r   <= {8'h00, flash_interface_status[6:0], 1'b0};
                    end else begin
                        so_out <= tx_r[STATUS_W-1];
                        tx_r   <= {tx_r[14:0], 1'b0};
                    end
                    so_oe_n  <= 1'b0;
                    tx_idx_r <= (tx_idx_r == STAT_LAST) ? 5'h00
                                                        : tx_idx_r + 5'h01;
                end
            end
        end
    end

    // =========================================================
    // checks next to the logic they guard
    property p_bad_opcode_waits;
        @(posedge clk) disable iff (reset)
        opc_full & (op_next == IF_IGNORE) & ~op_set |=> state_r == IF_IGNORE;
    endproperty
    a_bad_opcode_waits: assert property (p_bad_opcode_waits) // R01
        else $error("unknown opcode did not park the sequencer");

    property p_deselect_idle;
        @(posedge clk) disable iff (reset)
        cs_rise |=> (state_r == IF_OPCODE) && (bit_cnt_r == 5'h00)
                    && so_oe_n;
    endproperty
    a_deselect_idle: assert property (p_deselect_idle) // R02
        else $error("deselect did not return to idle");

    property p_latch_set;
        @(posedge clk) disable iff (reset)
        opc_full & op_set |=> ##1 flash_interface_status[ST_LATCH];
    endproperty
    a_latch_set: assert property (p_latch_set) // R08
        else $error("latch set opcode did not set the latch bit");

    property p_status_upper_zero;
        @(posedge clk) disable iff (reset)
        flash_interface_status[7:4] == STATUS_UNUSED;
    endproperty
    a_status_upper_zero: assert property (p_status_upper_zero) // R07
        else $error("status upper bits not zero");

    property p_busy_follows;
        @(posedge clk) disable iff (reset)
        flash_busy & ~READ_ONLY |=> ##1 flash_interface_status[ST_BUSY];
    endproperty
    a_busy_follows: assert property (p_busy_follows) // R09
        else $error("busy flag missed engine activity");

    property p_read_only_empty;
        @(posedge clk) disable iff (reset)
        READ_ONLY |-> flash_interface_status == STATUS_RESET;
    endproperty
    a_read_only_empty: assert property (p_read_only_empty) // R10
        else $error("read-only build shows a status register");

    property p_start_after_deselect;
        @(posedge clk) disable iff (reset)
        prog_start | erase_start |-> $past(cs_rise) && pin_s2_r.cs_n;
    endproperty
    a_start_after_deselect: assert property (p_start_after_deselect) // R22
        else $error("internal cycle started while selected");

    property p_busy_blocks_read;
        @(posedge clk) disable iff (reset)
        opc_full & busy_r & (opc_byte == data_read_cmd)
        |=> state_r == IF_IGNORE ##1 !rd_req [*4];
    endproperty
    a_busy_blocks_read: assert property (p_busy_blocks_read) // R15
        else $error("read accepted during programming");

    property p_write_skipped;
        @(posedge clk) disable iff (reset)
        addr_done & is_write_op & ~wr_allowed |=> state_r == IF_IGNORE;
    endproperty
    a_write_skipped: assert property (p_write_skipped) // R20
        else $error("write data accepted without latch or while protected");

endmodule

`default_nettype wire

// ### verification/flash_engine_model.sv
// behavioural flash array engine behind the command slave
`timescale 1ns/1ps
`default_nettype none
module flash_engine_model (
    input  wire logic        clk,
    input  wire logic        rd_req,
    input  wire logic [8:0]  rd_addr,
    input  wire logic        prog_start,
    input  wire logic [8:0]  prog_addr,
    input  wire logic [15:0] prog_data,
    input  wire logic        erase_start,
    input  wire logic [1:0]  erase_sel,
    output logic             rd_valid,
    output logic [15:0]      rd_data,
    output logic             flash_busy,
    output int               ops
);
    logic [15:0] mem [512];
    int          left;
    // ends of the array hold markers so a wrap is visible
    initial begin
        foreach (mem[i]) mem[i] = 16'hFFFF;
        mem[0] = 16'hA5A5;
        mem[511] = 16'h5A5A;
        left = 0;
        ops = 0;
        rd_valid = 1'b0;
        rd_data = 16'h0000;
    end
    assign flash_busy = (left != 0);
    // read data is not held: between fetches it toggles
    always @(posedge clk) begin
        rd_valid <= rd_req;
        rd_data <= rd_req ? mem[rd_addr] : ~rd_data;
        if (left != 0) left <= left - 1;
        if (prog_start) begin
            mem[prog_addr] <= prog_data;
            left <= 1500;
            ops <= ops + 1;
        end
        if (erase_start) begin
            foreach (mem[i])
                if (erase_sel[i/256]) mem[i] <= 16'hFFFF;
            left <= 1500;
            ops <= ops + 1;
        end
    end
endmodule
`default_nettype wire

// ### verification/spi_flash_command_slave_bench.sv
// self-checking bench: spi master tasks against the command slave
`timescale 1ns/1ps
`default_nettype none
module spi_flash_command_slave_bench;
    import spi_flash_pkg::*;
    logic        clk, reset, sck, cs_n, si, so_out, so_oe_n;
    logic        rd_req, rd_valid, prog_start, erase_start, busy;
    logic [8:0]  rd_addr, prog_addr;
    logic [15:0] rd_data, prog_data;
    logic [1:0]  erase_sel;
    logic [7:0]  st;
    logic [31:0] rx;
    logic        drove;
    int          ops, miscompares, checks_done;
    spi_flash_command_slave uut (.clk(clk), .reset(reset), .sck(sck),
        .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe_n(so_oe_n),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid),
        .rd_data(rd_data), .prog_start(prog_start),
        .prog_addr(prog_addr), .prog_data(prog_data),
        .erase_start(erase_start), .erase_sel(erase_sel),
        .flash_busy(busy), .flash_interface_status(st));
    flash_engine_model eng (.clk(clk), .rd_req(rd_req),
        .rd_addr(rd_addr), .prog_start(prog_start),
        .prog_addr(prog_addr), .prog_data(prog_data),
        .erase_start(erase_start), .erase_sel(erase_sel),
        .rd_valid(rd_valid), .rd_data(rd_data), .flash_busy(busy),
        .ops(ops));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ===========================================================
    // master tasks: sck idles low, 160 ns period, msb first
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bits(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            si = v[i];
            repeat (10) @(negedge clk);
            sck = 1'b1;
            rx = {rx[30:0], so_out};
            if (so_oe_n !== 1'b1) drove = 1'b1;
            repeat (10) @(negedge clk);
            sck = 1'b0;
        end
    endtask
    // select gap of 800 ns covers the select-to-clock setup
    task automatic frame(input logic [7:0] op, input logic [31:0] v,
                         input int n);
        drove = 1'b0;
        cs_n = 1'b0;
        repeat (100) @(negedge clk);
        bits({24'h0, op}, 8);
        bits(v, n);
        repeat (10) @(negedge clk);
        cs_n = 1'b1;
        repeat (80) @(negedge clk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ===========================================================
    // watchdog: the sequence needs about 18000 cycles
    initial begin
        repeat (80000) @(posedge clk);
        miscompares++;
        summarize();
    end
    initial begin
        {reset, sck, cs_n, si} = 4'b1010;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        repeat (30) @(negedge clk);
        check(st, 8'h00);
        frame(status_read_cmd, 0, 16);
        check(rx[15:0], 16'h0000);
        frame(latch_set_cmd, 0, 0);
        frame(status_read_cmd, 0, 8);
        check(rx[7:0], 8'h02);
        $display("test status done");
        frame(status_write_cmd, 8'hFF, 8);
        frame(status_read_cmd, 0, 8);
        check(rx[7:0], 8'h0E);
        frame(data_write_cmd, 32'h0005_1234, 32);
        frame(part_erase_cmd, 16'h0100, 16);
        check(16'(ops), 16'h0);
        frame(status_write_cmd, 8'h00, 8);
        // target word is still erased before it is written
        frame(data_write_cmd, 32'hFE05_1234, 32);
        check(16'(ops), 16'h1);
        frame(status_read_cmd, 0, 8);
        check(rx[7:0], 8'h03);
        frame(data_read_cmd, 16'h0005, 16);
        check(16'(drove), 16'h0);
        repeat (1600) @(negedge clk);
        $display("test write done");
        frame(data_read_cmd, 32'h0000_FE05, 48);
        check(rx[31:16], 16'h1234);
        check(rx[15:0], 16'hFFFF);
        frame(data_read_cmd, 32'h0000_01FF, 48);
        check(rx[31:16], 16'h5A5A);
        check(rx[15:0], 16'hA5A5);
        $display("test read done");
        frame(part_erase_cmd, 16'h0100, 16);
        check(16'(erase_sel), 16'h2);
        repeat (1600) @(negedge clk);
        frame(full_array_erase_cmd, 0, 0);
        check(16'(erase_sel), 16'h3);
        repeat (1600) @(negedge clk);
        frame(status_read_cmd, 0, 8);
        check(rx[7:0], 8'h02);
        frame(latch_clear_cmd, 0, 0);
        frame(full_array_erase_cmd, 0, 0);
        check(16'(ops), 16'h3);
        $display("test erase done");
        frame(8'hFF, 32'h0300_0000, 32);
        check(16'(drove), 16'h0);
        frame(status_read_cmd, 0, 8);
        check(rx[7:0], 8'h00);
        $display("test opcode done");
        summarize();
    end
endmodule
`default_nettype wire
